// ### hw/reset_source_controller.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

// Contract
// R1: in reset, halt the core, default registers, force ports, stop interrupts and timers.
// R2: reset leaves data memory untouched; only the stack pointer is reloaded.
// R3: during reset port latches are all ones, open drain; weak pullups stay on.
// R4: power-on and supply resets drive the reset pin low throughout reset.
// R5: on exit clear program counter, pick internal oscillator, fetch from zero.
// R6: after any reset the watchdog is on, clocked at system clock over twelve.
// R7: power-up applies a release delay after supply passes threshold.
// R8: power and supply resets set the power flag; other resets clear it.
// R9: power-on enables the supply monitor; other resets keep its state.
// R10: enabled supply monitor below threshold drives pin low and holds reset; here reset ends after one cycle, as its source select clears on entry.
// R11: supply-monitor reset releases without the power-on delay.
// R12: software enables the monitor and waits before selecting it as source.
// R13: supply control register at 0xFF; bit 7 enable, others read-only.
// R14: external low on the reset pin resets; pin flag set on exit.
// R15: clock-loss detector resets on a stuck clock and flags it.
// R16: writing the clock-loss flag bit enables or disables the detector.
// R17: enabled comparator resets while positive input is below negative; here reset ends after one cycle, as its enable clears on entry.
// R18: software lets the comparator settle before enabling it as source.
// R19: watchdog expiry resets and sets the watchdog flag.
// R20: illegal or blocked memory access, or write without monitor, resets and flags.
// R21: writing 1 to the soft reset bit resets; the bit reads 1 afterwards.
// R22: clock-loss, comparator, watchdog, memory and soft resets leave pin undriven.
// R23: reset cause register at 0xEF with bits pin..memory; bit 7 reads zero.
// R24: software must not read-modify-write the reset cause register.
// R25: all enabled requests merge into one synchronous reset; flags are latched.
module reset_source_controller
   import reset_ctrl_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   input  wire logic        supply_above_threshold,
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   input  wire logic        clock_activity,
   input  wire logic        comparator_pos_above_neg,
   input  wire logic        watchdog_expired,
   input  wire logic        memory_access_error,
   output logic             system_reset,
   output logic             core_halt,
   output logic             port_latch_force,
   output logic [7:0]       port_latch_value,
   output logic             port_open_drain,
   output logic             weak_pullup_en,
   output logic             interrupts_disable,
   output logic [15:0]      program_counter_load,
   output logic             internal_osc_select,
   output logic             watchdog_enable,
   output logic [3:0]       watchdog_clock_div,
   output logic             supply_monitor_enable
);

   typedef enum logic [1:0] {ST_POWER_UP, ST_RESET, ST_RUN} seq_state_e;

   seq_state_e             state_reg,      state_next;
   logic [DELAY_W-1:0]     delay_reg,      delay_next;
   logic [7:0]             cause_reg,      cause_next;
   logic                   mon_en_reg,     mon_en_next;
   logic                   mon_src_reg,    mon_src_next;
   logic                   clk_det_en_reg, clk_det_en_next;
   logic                   comp_en_reg,    comp_en_next;
   logic [7:0]             rdata_reg,      rdata_next;
   logic                   pin_drive_reg,  pin_drive_next;
   logic                   soft_req_reg,   soft_req_next;
   logic [3:0]             stuck_reg,      stuck_next;
   logic                   last_act_reg,   last_act_next;
   logic [7:0]             req_cause;
   logic                   power_req;
   logic                   any_req;
   logic                   in_reset;

   // clock-loss watch: count cycles with no toggle on the monitored clock
   always_comb begin
      last_act_next = clock_activity;
      if (clock_activity != last_act_reg) begin
         stuck_next = 4'h0;
      end else if (stuck_reg != 4'hF) begin
         stuck_next = stuck_reg + 4'h1;
      end else begin
         stuck_next = stuck_reg;
      end
   end

   // request gathering; a supply low only counts while monitor is on
   always_comb begin
      req_cause = 8'h00;
      // R10 monitor below threshold
      power_req = mon_en_reg && mon_src_reg && !supply_above_threshold;
      // R14 external pin low
      req_cause[PIN_FLAG_BIT]   = !reset_pin_in && !pin_drive_reg;
      req_cause[POWER_FLAG_BIT] = power_req;
      // R15 stuck clock timeout
      req_cause[CLOCK_FLAG_BIT] = clk_det_en_reg && (32'(stuck_reg) >= CLOCK_TIMEOUT_CYC);
      // R19 watchdog expiry
      req_cause[WDOG_FLAG_BIT]  = watchdog_expired;
      // R21 soft reset request
      req_cause[SOFT_FLAG_BIT]  = soft_req_reg;
      // R17 comparator active low
      req_cause[COMP_FLAG_BIT]  = comp_en_reg && !comparator_pos_above_neg;
      // R20 memory access fault
      req_cause[MEM_FLAG_BIT]   = memory_access_error;
      // R25 merge all requests
      any_req = |req_cause;
   end

   assign in_reset = (state_reg != ST_RUN);

   // sequencer, cause flags and register port
   always_comb begin
      state_next      = state_reg;
      delay_next      = delay_reg;
      cause_next      = cause_reg;
      mon_en_next     = mon_en_reg;
      mon_src_next    = mon_src_reg;
      clk_det_en_next = clk_det_en_reg;
      comp_en_next    = comp_en_reg;
      pin_drive_next  = pin_drive_reg;
      soft_req_next   = 1'b0;
      rdata_next      = 8'h00;
      case (state_reg)
         ST_POWER_UP: begin
            // R7 wait for supply, then count the release delay
            if (!supply_above_threshold) begin
               delay_next = '0;
            end else if (32'(delay_reg) >= POR_DELAY_CYCLES - 1) begin
               state_next     = ST_RUN;
               pin_drive_next = 1'b0;
            end else begin
               delay_next = delay_reg + 1'b1;
            end
         end
         ST_RESET: begin
            // R11 release as soon as every request is gone, no delay
            if (!any_req) begin
               state_next     = ST_RUN;
               pin_drive_next = 1'b0;
            end
         end
         ST_RUN: begin
            if (any_req) begin
               state_next = ST_RESET;
               // R8 power flag set alone, others leave it clear
               if (req_cause[POWER_FLAG_BIT]) begin
                  cause_next                 = CAUSE_POR_VALUE;
                  // R4 pin low for supply resets
                  pin_drive_next             = 1'b1;
               end else begin
                  // R25 latch the requests as the cause; enable bits are not kept
                  cause_next                 = req_cause;
                  cause_next[POWER_FLAG_BIT] = 1'b0;
                  // R22 pin left undriven
                  pin_drive_next             = 1'b0;
               end
               // source enables, the monitor select included, fall back on reset; the monitor enable is kept
               mon_src_next    = 1'b0;
               clk_det_en_next = 1'b0;
               comp_en_next    = 1'b0;
            end else if (reg_write) begin
               // R13 only the enable bit is writable
               if (reg_addr == SUPPLY_CTRL_ADDR) begin
                  mon_en_next = reg_wdata[SUPPLY_EN_BIT];
               end
               // R23 write side: enables and soft force
               if (reg_addr == RESET_CAUSE_ADDR) begin
                  mon_src_next    = reg_wdata[POWER_FLAG_BIT];
                  // R16 clock-loss enable
                  clk_det_en_next = reg_wdata[CLOCK_FLAG_BIT];
                  comp_en_next    = reg_wdata[COMP_FLAG_BIT];
                  soft_req_next   = reg_wdata[SOFT_FLAG_BIT];
               end
            end
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
      // reads answer one cycle later; bit 7 of the cause reads zero
      if (reg_read) begin
         case (reg_addr)
            SUPPLY_CTRL_ADDR: begin
               rdata_next[SUPPLY_EN_BIT]   = mon_en_reg;
               rdata_next[SUPPLY_STAT_BIT] = supply_above_threshold;
            end
            RESET_CAUSE_ADDR: begin
               rdata_next = {1'b0, cause_reg[6:0]};
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   // state registers; power-on is the asynchronous root reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg      <= ST_POWER_UP;
         delay_reg      <= '0;
         cause_reg      <= CAUSE_POR_VALUE;
         // R9 power-on enables the monitor
         mon_en_reg     <= SUPPLY_EN_POR;
         mon_src_reg    <= 1'b1;
         clk_det_en_reg <= 1'b0;
         comp_en_reg    <= 1'b0;
         rdata_reg      <= 8'h00;
         pin_drive_reg  <= 1'b1;
         soft_req_reg   <= 1'b0;
         stuck_reg      <= 4'h0;
         last_act_reg   <= 1'b0;
      end else if (clk_en) begin
         state_reg      <= state_next;
         delay_reg      <= delay_next;
         cause_reg      <= cause_next;
         mon_en_reg     <= mon_en_next;
         mon_src_reg    <= mon_src_next;
         clk_det_en_reg <= clk_det_en_next;
         comp_en_reg    <= comp_en_next;
         rdata_reg      <= rdata_next;
         pin_drive_reg  <= pin_drive_next;
         soft_req_reg   <= soft_req_next;
         stuck_reg      <= stuck_next;
         last_act_reg   <= last_act_next;
      end
   end

   // registered outputs derived from the next reset state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         system_reset          <= 1'b1;
         core_halt             <= 1'b1;
         port_latch_force      <= 1'b1;
         port_latch_value      <= PORT_LATCH_RESET;
         port_open_drain       <= 1'b1;
         weak_pullup_en        <= 1'b1;
         interrupts_disable    <= 1'b1;
         program_counter_load  <= START_ADDRESS;
         internal_osc_select   <= 1'b1;
         watchdog_enable       <= 1'b1;
         watchdog_clock_div    <= WDOG_DIVIDE;
         supply_monitor_enable <= SUPPLY_EN_POR;
         reset_pin_out         <= 1'b0;
         reset_pin_oe          <= 1'b1;
         reg_rdata             <= 8'h00;
      end else if (clk_en) begin
         // R1 halt, defaults, ports and interrupts while in reset
         system_reset          <= (state_next != ST_RUN);
         core_halt             <= (state_next != ST_RUN);
         interrupts_disable    <= (state_next != ST_RUN);
         // R3 latches all ones, open drain; pullups always on
         port_latch_force      <= (state_next != ST_RUN);
         port_open_drain       <= (state_next != ST_RUN);
         port_latch_value      <= PORT_LATCH_RESET;
         weak_pullup_en        <= 1'b1;
         // R5 restart from zero on the internal oscillator
         program_counter_load  <= START_ADDRESS;
         internal_osc_select   <= in_reset ? 1'b1 : internal_osc_select;
         // R6 watchdog on at divide by twelve after every reset
         watchdog_enable       <= 1'b1;
         watchdog_clock_div    <= WDOG_DIVIDE;
         supply_monitor_enable <= mon_en_next;
         // R4 drive the pin low only for power resets
         reset_pin_out         <= 1'b0;
         reset_pin_oe          <= pin_drive_next;
         reg_rdata             <= rdata_next;
      end
   end

   // R2 no data memory state is held or cleared in this block
endmodule // reset_source_controller

// ### hw/reset_ctrl_pkg.sv
package reset_ctrl_pkg;
   // register addresses on the special function port
   localparam logic [7:0] SUPPLY_CTRL_ADDR   = 8'hFF;
   localparam logic [7:0] RESET_CAUSE_ADDR   = 8'hEF;
   // supply monitor control fields
   localparam int         SUPPLY_EN_BIT      = 7;
   localparam int         SUPPLY_STAT_BIT    = 6;
   // reset cause fields
   localparam int         PIN_FLAG_BIT       = 0;
   localparam int         POWER_FLAG_BIT     = 1;
   localparam int         CLOCK_FLAG_BIT     = 2;
   localparam int         WDOG_FLAG_BIT      = 3;
   localparam int         SOFT_FLAG_BIT      = 4;
   localparam int         COMP_FLAG_BIT      = 5;
   localparam int         MEM_FLAG_BIT       = 6;
   // values after power-on
   localparam logic [7:0] CAUSE_POR_VALUE    = 8'h02;
   localparam logic       SUPPLY_EN_POR      = 1'b1;
   localparam logic [7:0] PORT_LATCH_RESET   = 8'hFF;
   localparam logic [15:0] START_ADDRESS     = 16'h0000;
   localparam logic [3:0] WDOG_DIVIDE        = 4'hC;
   // power-on release delay
   localparam real        CLOCK_PERIOD_NS    = 40.0;
   localparam real        POR_DELAY_US       = 300.0;
   localparam int         POR_DELAY_CYCLES   = int'(POR_DELAY_US * 1000.0 / CLOCK_PERIOD_NS);
   // clock-loss time-out in system clocks of no activity
   localparam int         CLOCK_TIMEOUT_CYC  = 8;
   // width of the release counter
   localparam int         DELAY_W            = 16;
endpackage

// ### sim/reset_source_controller_properties.sv
`timescale 1ns/1ps
module reset_source_controller_properties
   import reset_ctrl_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        clk_en,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   input wire logic        watchdog_expired,
   input wire logic        memory_access_error,
   input wire logic        reset_pin_out,
   input wire logic        reset_pin_oe,
   input wire logic        system_reset,
   input wire logic        core_halt,
   input wire logic        interrupts_disable,
   input wire logic [7:0]  port_latch_value,
   input wire logic        port_open_drain,
   input wire logic        weak_pullup_en,
   input wire logic [15:0] program_counter_load,
   input wire logic        internal_osc_select,
   input wire logic        watchdog_enable,
   input wire logic [3:0]  watchdog_clock_div
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // reset-state outputs follow the reset itself
   a_halt_in_reset: assert property (system_reset |-> core_halt && interrupts_disable)
      else $error("core not halted in reset");
   a_ports_forced: assert property (system_reset |->
      port_latch_value == PORT_LATCH_RESET && port_open_drain) else $error("ports not forced");
   a_pullup_kept: assert property (weak_pullup_en)
      else $error("weak pullups off");
   // pin driven only low, and never long past the reset
   a_pin_drive_low: assert property (reset_pin_oe |->
      !reset_pin_out && (system_reset || $past(system_reset))) else $error("bad pin drive");
   a_exit_state: assert property (!system_reset |->
      program_counter_load == START_ADDRESS && internal_osc_select) else $error("bad exit state");
   a_wdog_setup: assert property (watchdog_enable && watchdog_clock_div == WDOG_DIVIDE)
      else $error("watchdog setup wrong");
   // requests reach the merged reset within a few cycles
   a_soft_request: assert property (clk_en && reg_write && reg_addr == RESET_CAUSE_ADDR
      && reg_wdata[SOFT_FLAG_BIT] && !system_reset |-> ##[1:3] system_reset)
      else $error("soft request lost");
   a_wdog_request: assert property (clk_en && watchdog_expired && !system_reset
      |-> ##[1:3] system_reset) else $error("watchdog request lost");
   a_mem_request: assert property (clk_en && memory_access_error && !system_reset
      |-> ##[1:3] system_reset) else $error("memory request lost");
   a_ro_bits_zero: assert property (clk_en && reg_read && reg_addr == SUPPLY_CTRL_ADDR
      |=> reg_rdata[5:0] == 6'h00) else $error("read-only bits set");
   c_pin_driven: cover property ($rose(reset_pin_oe));
   c_reset_left: cover property ($fell(system_reset));
   c_wdog_seen: cover property (watchdog_expired && !system_reset);
endmodule // reset_source_controller_properties

bind reset_source_controller reset_source_controller_properties
   i_reset_source_controller_properties (.*);

// ### sim/reset_far_side.sv
`timescale 1ns/1ps
module reset_far_side (
   input  wire logic sys_clk,
   input  wire logic supply_ok,
   input  wire logic ext_low,
   input  wire logic clock_stop,
   input  wire logic reset_pin_out,
   input  wire logic reset_pin_oe,
   output logic      supply_above_threshold,
   output logic      reset_pin_in,
   output logic      clock_activity = 1'b0
);
   assign supply_above_threshold = supply_ok;
   // pulled up, low when either side pulls
   assign reset_pin_in = !ext_low && !(reset_pin_oe && !reset_pin_out);
   // a stuck clock freezes at its last level
   always @(posedge sys_clk) clock_activity <= clock_stop ? clock_activity : !clock_activity;
endmodule // reset_far_side

// ### sim/reset_source_controller_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module reset_source_controller_tb_top
   import reset_ctrl_pkg::*;
();
   logic sys_clk = 0, rstn = 0, clk_en = 1, reg_write = 0, reg_read = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, port_latch_value;
   logic supply_ok = 1, ext_low = 0, clock_stop = 0, comparator_pos_above_neg = 1;
   logic watchdog_expired = 0, memory_access_error = 0, supply_above_threshold;
   logic reset_pin_in, reset_pin_out, reset_pin_oe, clock_activity, system_reset;
   logic core_halt, port_latch_force, port_open_drain, weak_pullup_en, interrupts_disable;
   logic internal_osc_select, watchdog_enable, supply_monitor_enable;
   logic [15:0] program_counter_load;
   logic [3:0] watchdog_clock_div;
   int n_errors = 0, n_compared = 0;
   reset_source_controller i_reset_source_controller (.*);
   reset_far_side i_reset_far_side (.*);
   // free-running system clock
   initial forever #20 sys_clk = ~sys_clk;
   task automatic final_report();
      if (n_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_write <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_write <= 0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_read <= 1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 0;
      #1 `CHK(reg_rdata, exp)
   endtask
   // bounded wait for one reset to come and go, then read its cause
   task automatic cycle_reset(input int limit, input logic [7:0] cause, input logic oe_exp);
      logic hit = 0, oe = 0;
      for (int i = 0; i < limit && !(hit && system_reset === 1'b0); i++) begin
         @(negedge sys_clk);
         hit |= system_reset;
         oe |= reset_pin_oe;
      end
      `CHK(hit && system_reset === 1'b0, 1'b1)
      `CHK(oe, oe_exp)
      rd(RESET_CAUSE_ADDR, cause);
   endtask
   task automatic pulse(input bit mem);
      @(posedge sys_clk);
      if (mem) memory_access_error <= 1;
      else watchdog_expired <= 1;
      @(posedge sys_clk);
      memory_access_error <= 0;
      watchdog_expired <= 0;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge sys_clk);
      `CHK(reset_pin_oe, 1'b1)
      `CHK(port_latch_value, PORT_LATCH_RESET)
      rstn <= 1;
      cycle_reset(POR_DELAY_CYCLES + 60, CAUSE_POR_VALUE, 1'b1);
      rd(SUPPLY_CTRL_ADDR, 8'hC0);
      rd(8'h10, 8'h00);
      wr(SUPPLY_CTRL_ADDR, 8'h3F);
      rd(SUPPLY_CTRL_ADDR, 8'h40);
      `CHK(supply_monitor_enable, 1'b0)
      // cause writes carry only chosen enables, never a read-back value
      wr(RESET_CAUSE_ADDR, 8'h10);
      cycle_reset(30, 8'h10, 1'b0);
      rd(SUPPLY_CTRL_ADDR, 8'h40);
      pulse(0);
      cycle_reset(30, 8'h08, 1'b0);
      pulse(1);
      cycle_reset(30, 8'h40, 1'b0);
      fork
         cycle_reset(30, 8'h01, 1'b0);
         begin
            @(posedge sys_clk);
            ext_low <= 1;
            repeat (3) @(posedge sys_clk);
            ext_low <= 0;
         end
      join
      // detector off after reset: a stuck clock must pass unnoticed
      clock_stop <= 1;
      repeat (12) begin
         @(negedge sys_clk);
         `CHK(system_reset, 1'b0)
      end
      clock_stop <= 0;
      wr(RESET_CAUSE_ADDR, 8'h04);
      fork
         cycle_reset(40, 8'h04, 1'b0);
         begin
            clock_stop <= 1;
            repeat (12) @(posedge sys_clk);
            clock_stop <= 0;
         end
      join
      // comparator already settled high before it is selected
      wr(RESET_CAUSE_ADDR, 8'h20);
      fork
         cycle_reset(30, 8'h20, 1'b0);
         begin
            comparator_pos_above_neg <= 0;
            repeat (4) @(posedge sys_clk);
            comparator_pos_above_neg <= 1;
         end
      join
      // enable the monitor, let it settle, then select it
      wr(SUPPLY_CTRL_ADDR, 8'h80);
      repeat (4) @(posedge sys_clk);
      wr(RESET_CAUSE_ADDR, 8'h02);
      fork
         cycle_reset(40, CAUSE_POR_VALUE, 1'b1);
         begin
            supply_ok <= 0;
            repeat (5) @(posedge sys_clk);
            supply_ok <= 1;
         end
      join
      final_report();
   end
   // cut a hang short well past the expected run
   initial begin
      #2000000;
      n_errors++;
      final_report();
   end
endmodule // reset_source_controller_tb_top
